// ---- core/ledbco_ctrl.sv ----
// Top of the LED drive blanking sequencer and constant-off controller with APB registers.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module ledbco_ctrl
    import ledbco_pkg::*;
#(
    parameter int DAC_W  = LEDBCO_DAC_W,
    parameter int OFFT_W = LEDBCO_OFFT_W,
    parameter int SEL_W  = LEDBCO_SEL_W
) (
    // APB slave.
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Display controller requests.
    input  wire logic [SEL_W-1:0]  led_select_req,
    input  wire logic              drive_enable_req,
    input  wire logic              low_r_shunt_req,
    input  wire logic              dissipative_shunt_req,
    // Analog comparators.
    input  wire logic              photo_comp,
    input  wire logic              peak_limit_trip,
    // Outputs to buck controller, shunt and LED FET drivers.
    output logic                   cap_mode_select,
    output logic                   buck_drive_enable,
    output logic                   low_r_shunt_enable,
    output logic                   dissipative_shunt_enable,
    output logic      [SEL_W-1:0]  led_select,
    output logic      [DAC_W-1:0]  peak_limit_dac
);

    // Pin synchronisers: stage one is read only by stage two.
    localparam int SYNC_W = SEL_W + 5;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {led_select_req, drive_enable_req, low_r_shunt_req, dissipative_shunt_req,
                          photo_comp, peak_limit_trip};
            sync2_reg <= sync1_reg;
        end
    end

    logic [SEL_W-1:0] sel_s;
    logic             drv_s;
    logic             lrs_s;
    logic             dis_s;
    logic             comp_s;
    logic             trip_s;
    assign {sel_s, drv_s, lrs_s, dis_s, comp_s, trip_s} = sync2_reg;

    // Registers.
    logic [31:0]       ctrl_reg;
    logic [31:0]       ctrl_next;
    logic [DAC_W-1:0]  peak_limit_dac_reg;
    logic [DAC_W-1:0]  peak_limit_dac_next;
    logic [OFFT_W-1:0] offt_reg;
    logic [OFFT_W-1:0] offt_next;
    logic [31:0]       prdata_reg;
    logic [31:0]       prdata_next;
    logic              pready_reg;
    logic              pready_next;
    logic              pslverr_reg;
    logic              pslverr_next;

    logic disc_mode;
    logic enabled;
    assign disc_mode = ctrl_reg[LEDBCO_CTRL_DISC_BIT];
    assign enabled   = ctrl_reg[LEDBCO_CTRL_ENABLE_BIT];

    // Sequencer state.
    ledbco_state_t state_reg;
    ledbco_state_t state_next;
    logic [3:0]    tog_reg;
    logic [3:0]    tog_next;
    logic [SEL_W-1:0] sel_hold_reg;
    logic [SEL_W-1:0] sel_hold_next;
    logic          comp_d_reg;
    logic          off_running;
    logic          off_start;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    // Single-wait APB slave: the access phase completes one cycle after it begins.
    logic access;
    assign access = psel && penable && !pready_reg;

    always_comb begin
        ctrl_next    = ctrl_reg;
        peak_limit_dac_next    = peak_limit_dac_reg;
        offt_next    = offt_reg;
        prdata_next  = prdata_reg;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (access) begin
            pready_next = 1'b1;
            prdata_next = LEDBCO_UNMAPPED_RD;
            if (addr_hit(paddr, LEDBCO_CTRL_OFFSET)) begin
                if (pwrite) ctrl_next = {30'h0, pwdata[1:0]};
                prdata_next = ctrl_reg;
            end else if (addr_hit(paddr, LEDBCO_PEAK_LIMIT_DAC_OFFSET)) begin
                if (pwrite) peak_limit_dac_next = pwdata[DAC_W-1:0];
                prdata_next = {{(32-DAC_W){1'b0}}, peak_limit_dac_reg};
            end else if (addr_hit(paddr, LEDBCO_OFFT_OFFSET)) begin
                if (pwrite) offt_next = pwdata[OFFT_W-1:0];
                prdata_next = {{(32-OFFT_W){1'b0}}, offt_reg};
            end else if (addr_hit(paddr, LEDBCO_STATUS_OFFSET)) begin
                prdata_next = {{(32-SEL_W-7){1'b0}}, sel_hold_reg, off_running, comp_s, state_reg};
            end else begin
                pslverr_next = 1'b1;
            end
            if (pwrite) prdata_next = LEDBCO_UNMAPPED_RD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= LEDBCO_CTRL_RESET;
            peak_limit_dac_reg    <= LEDBCO_PEAK_LIMIT_DAC_RESET;
            offt_reg    <= LEDBCO_OFFT_RESET;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            peak_limit_dac_reg    <= peak_limit_dac_next;
            offt_reg    <= offt_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // A threshold event is the comparator falling: light has risen above the reference.
    assign off_start = (state_reg == LEDBCO_ST_HYST) && !disc_mode && comp_d_reg && !comp_s;

    ledbco_offtimer #(
        .CNT_W (OFFT_W)
    ) u_offtimer (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (off_start),
        .terminal (offt_reg),
        .running  (off_running)
    );

    // Blanking sequencer.
    always_comb begin
        state_next    = state_reg;
        tog_next      = tog_reg;
        sel_hold_next = sel_hold_reg;
        if (!enabled || disc_mode) begin
            state_next = LEDBCO_ST_IDLE;
        end else begin
            unique case (state_reg)
                LEDBCO_ST_IDLE: begin
                    if (dis_s) state_next = LEDBCO_ST_DISSIP;
                    else if (lrs_s) state_next = LEDBCO_ST_CHARGE;
                    else if (drv_s && sel_s != '0) begin
                        sel_hold_next = sel_s;
                        state_next    = LEDBCO_ST_HYST;
                    end
                end
                LEDBCO_ST_DISSIP: begin
                    if (lrs_s) state_next = LEDBCO_ST_CHARGE;
                end
                LEDBCO_ST_CHARGE: begin
                    // Charging runs until the shunt request drops and either the peak limit trips or the drive request is low.
                    if (!lrs_s && trip_s) begin
                        sel_hold_next = sel_s;
                        tog_next      = LEDBCO_TOGGLE_CYC;
                        state_next    = LEDBCO_ST_TOGGLE;
                    end else if (!lrs_s && !drv_s) begin
                        state_next = LEDBCO_ST_IDLE;
                    end
                end
                LEDBCO_ST_TOGGLE: begin
                    tog_next = tog_reg - 4'h1;
                    if (tog_reg == 4'h1) state_next = LEDBCO_ST_HYST;
                end
                LEDBCO_ST_HYST: begin
                    if (dis_s) state_next = LEDBCO_ST_DISSIP;
                    else if (lrs_s) state_next = LEDBCO_ST_CHARGE;
                    else if (!drv_s) state_next = LEDBCO_ST_IDLE;
                end
                default: state_next = LEDBCO_ST_IDLE;
            endcase
        end
    end

    // Output decode, registered so every output leaves a flip-flop.
    logic             cap_next;
    logic             drv_next;
    logic             lrs_next;
    logic             dis_next;
    logic [SEL_W-1:0] sel_next;

    always_comb begin
        cap_next = disc_mode;
        drv_next = 1'b0;
        lrs_next = 1'b0;
        dis_next = 1'b0;
        sel_next = '0;
        unique case (state_next)
            LEDBCO_ST_DISSIP: begin
                dis_next = 1'b1;
            end
            LEDBCO_ST_CHARGE: begin
                lrs_next = 1'b1;
                drv_next = !trip_s;
            end
            LEDBCO_ST_TOGGLE: begin
                sel_next = sel_hold_next;
            end
            LEDBCO_ST_HYST: begin
                sel_next = sel_hold_next;
                // Comparator high means light below reference; the off timer overrides it.
                drv_next = comp_s && !off_running && !off_start;
            end
            default: begin
                drv_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg                <= LEDBCO_ST_IDLE;
            tog_reg                  <= 4'h0;
            sel_hold_reg             <= '0;
            comp_d_reg               <= 1'b0;
            cap_mode_select          <= 1'b0;
            buck_drive_enable        <= 1'b0;
            low_r_shunt_enable       <= 1'b0;
            dissipative_shunt_enable <= 1'b0;
            led_select               <= '0;
            peak_limit_dac           <= LEDBCO_PEAK_LIMIT_DAC_RESET;
        end else begin
            state_reg                <= state_next;
            tog_reg                  <= tog_next;
            sel_hold_reg             <= sel_hold_next;
            comp_d_reg               <= comp_s;
            cap_mode_select          <= cap_next;
            buck_drive_enable        <= drv_next;
            low_r_shunt_enable       <= lrs_next;
            dissipative_shunt_enable <= dis_next;
            led_select               <= sel_next;
            peak_limit_dac           <= peak_limit_dac_reg;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

endmodule

// ---- core/ledbco_pkg.sv ----
// Package with constants and types for the LED drive blanking and off-time controller.
package ledbco_pkg;

    // Register byte offsets.
    localparam logic [11:0] LEDBCO_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] LEDBCO_PEAK_LIMIT_DAC_OFFSET   = 12'h004;
    localparam logic [11:0] LEDBCO_OFFT_OFFSET   = 12'h008;
    localparam logic [11:0] LEDBCO_STATUS_OFFSET = 12'h00c;

    // Control register fields.
    localparam int LEDBCO_CTRL_DISC_BIT   = 0;
    localparam int LEDBCO_CTRL_ENABLE_BIT = 1;

    // Widths.
    localparam int LEDBCO_DAC_W  = 10;
    localparam int LEDBCO_OFFT_W = 16;
    localparam int LEDBCO_SEL_W  = 4;

    // Reset values.
    localparam logic [31:0]              LEDBCO_CTRL_RESET = 32'h0000_0000;
    localparam logic [LEDBCO_DAC_W-1:0]  LEDBCO_PEAK_LIMIT_DAC_RESET = 10'h000;
    localparam logic [LEDBCO_OFFT_W-1:0] LEDBCO_OFFT_RESET = 16'h0014;

    // Toggle of the drive enable at the end of blanking: low time in ns and cycles at 20 MHz.
    localparam int LEDBCO_CLK_HZ        = 20_000_000;
    localparam int LEDBCO_TOGGLE_NS     = 100;
    localparam int LEDBCO_TOGGLE_CYC_I  = (LEDBCO_TOGGLE_NS * (LEDBCO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] LEDBCO_TOGGLE_CYC = (LEDBCO_TOGGLE_CYC_I < 1) ? 4'h1 : 4'(LEDBCO_TOGGLE_CYC_I);

    // Read value for an unmapped address.
    localparam logic [31:0] LEDBCO_UNMAPPED_RD = 32'h0000_0000;

    typedef enum logic [4:0] {
        LEDBCO_ST_IDLE   = 5'b00001,
        LEDBCO_ST_DISSIP = 5'b00010,
        LEDBCO_ST_CHARGE = 5'b00100,
        LEDBCO_ST_TOGGLE = 5'b01000,
        LEDBCO_ST_HYST   = 5'b10000
    } ledbco_state_t;

endpackage

// ---- core/ledbco_offtimer.sv ----
// Constant-off timer that masks the photo comparator after each threshold event.
`timescale 1ns/1ps
module ledbco_offtimer
    import ledbco_pkg::*;
#(
    parameter int CNT_W = LEDBCO_OFFT_W
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control.
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] terminal,
    // Status.
    output logic                  running
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             run_reg;
    logic             run_next;

    always_comb begin
        count_next = count_reg;
        run_next   = run_reg;
        if (run_reg) begin
            if (count_reg >= terminal) begin
                run_next = 1'b0;
            end else begin
                count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (start) begin
            // A start while running is ignored, so the count cannot be stretched by comparator chatter.
            run_next   = 1'b1;
            count_next = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
        end
    end

    assign running = run_reg;

endmodule

// ---- testbench/ledbco_ctrl_assertions.sv ----
// Port checker for the blanking sequencer and constant-off timer.
`timescale 1ns/1ps
module ledbco_ctrl_assertions
    import ledbco_pkg::*;
#(
    parameter int DAC_W = LEDBCO_DAC_W,
    parameter int SEL_W = LEDBCO_SEL_W
) (
    // APB side.
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    // Sequencer pins.
    input wire logic             photo_comp,
    input wire logic             peak_limit_trip,
    input wire logic             cap_mode_select,
    input wire logic             buck_drive_enable,
    input wire logic             low_r_shunt_enable,
    input wire logic             dissipative_shunt_enable,
    input wire logic [SEL_W-1:0] led_select,
    input wire logic [DAC_W-1:0] peak_limit_dac
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        wr, drv_q, nz_q;
    logic [15:0] offt_reg, offt_next;
    logic [7:0]  low_reg, low_next;
    assign wr = psel && penable && pready && pwrite;
    always_comb begin
        offt_next = offt_reg;
        low_next  = low_reg;
        if (wr && paddr[11:2] == LEDBCO_OFFT_OFFSET[11:2])
            offt_next = pwdata[15:0];
        // Only a fall with a lit LED starts a count, so the toggle pulse is not taken for off time.
        if (buck_drive_enable || led_select == '0)
            low_next = 8'h00;
        else if (drv_q && nz_q)
            low_next = 8'h01;
        else if (low_reg != 8'h00 && low_reg != 8'hff)
            low_next = low_reg + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offt_reg <= LEDBCO_OFFT_RESET;
            low_reg  <= 8'h00;
            drv_q    <= 1'b0;
            nz_q     <= 1'b0;
        end else begin
            offt_reg <= offt_next;
            low_reg  <= low_next;
            drv_q    <= buck_drive_enable;
            nz_q     <= led_select != '0;
        end
    end
    property p_cap;
        wr && paddr[11:2] == LEDBCO_CTRL_OFFSET[11:2] |-> ##2 cap_mode_select == $past(pwdata[0], 2);
    endproperty
    a_cap: assert property (p_cap) else $error("cap mode wrong");
    property p_dac;
        wr && paddr[11:2] == LEDBCO_PEAK_LIMIT_DAC_OFFSET[11:2] |-> ##2 peak_limit_dac == $past(pwdata[DAC_W-1:0], 2);
    endproperty
    a_dac: assert property (p_dac) else $error("dac wrong");
    property p_dis;
        dissipative_shunt_enable |-> led_select == '0 && !buck_drive_enable && !low_r_shunt_enable;
    endproperty
    a_dis: assert property (p_dis) else $error("dissipation wrong");
    property p_chg;
        low_r_shunt_enable |-> buck_drive_enable == !$past(peak_limit_trip, 3) && led_select == '0;
    endproperty
    a_chg: assert property (p_chg) else $error("charge wrong");
    property p_end;
        $fell(low_r_shunt_enable) && led_select != '0 |->
            !buck_drive_enable ##1 !buck_drive_enable && $stable(led_select);
    endproperty
    a_end: assert property (p_end) else $error("toggle wrong");
    property p_hys;
        buck_drive_enable && led_select != '0 |-> $past(photo_comp, 3);
    endproperty
    a_hys: assert property (p_hys) else $error("drive without demand");
    property p_off;
        $rose(buck_drive_enable) && low_reg != 8'h00 |-> {8'h00, low_reg} >= offt_reg + 16'h0002;
    endproperty
    a_off: assert property (p_off) else $error("off time short");
    property p_exp;
        low_reg != 8'h00 && {8'h00, low_reg} > offt_reg + 16'h0002 && led_select != '0 && !low_r_shunt_enable
            && $past(photo_comp, 3) |-> buck_drive_enable;
    endproperty
    a_exp: assert property (p_exp) else $error("off time long");
    c_end: cover property ($fell(low_r_shunt_enable) && led_select != '0);
    c_off: cover property ($rose(buck_drive_enable) && low_reg != 8'h00);
    c_cap: cover property (cap_mode_select);
endmodule

bind ledbco_ctrl ledbco_ctrl_assertions #(.DAC_W(DAC_W), .SEL_W(SEL_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .photo_comp(photo_comp),
    .peak_limit_trip(peak_limit_trip), .cap_mode_select(cap_mode_select),
    .buck_drive_enable(buck_drive_enable), .low_r_shunt_enable(low_r_shunt_enable),
    .dissipative_shunt_enable(dissipative_shunt_enable), .led_select(led_select),
    .peak_limit_dac(peak_limit_dac)
);

// ---- testbench/ledbco_far_model.sv ----
// Behavioural model of the inductor current and light level seen by the controller.
`timescale 1ns/1ps
module ledbco_far_model
    import ledbco_pkg::*;
#(
    parameter logic [7:0] LIGHT_REF = 8'h10
) (
    // Clock and reset.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // Controller outputs.
    input  wire logic                    buck_drive_enable,
    input  wire logic                    low_r_shunt_enable,
    input  wire logic [LEDBCO_SEL_W-1:0] led_select,
    input  wire logic [LEDBCO_DAC_W-1:0] peak_limit_dac,
    // Comparator results.
    output logic                         photo_comp,
    output logic                         peak_limit_trip
);
    logic [LEDBCO_DAC_W-1:0] cur_reg;
    logic [7:0]              light_reg;
    // The short-circuit shunt loses almost nothing, so current holds while it is on and the drive is off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg   <= '0;
            light_reg <= 8'h00;
        end else begin
            if (buck_drive_enable && cur_reg != '1)
                cur_reg <= cur_reg + 1'b1;
            else if (!buck_drive_enable && !low_r_shunt_enable && cur_reg != '0)
                cur_reg <= cur_reg - 1'b1;
            if (buck_drive_enable && led_select != '0 && !low_r_shunt_enable)
                light_reg <= light_reg + 8'h01;
            else
                light_reg <= (light_reg > 8'h01) ? light_reg - 8'h02 : 8'h00;
        end
    end
    assign photo_comp      = light_reg < LIGHT_REF;
    assign peak_limit_trip = cur_reg >= peak_limit_dac;
endmodule

// ---- testbench/led_drive_blanking_offtime_ctrl_tb_top.sv ----
// Testbench for the blanking sequencer and constant-off timer.
`timescale 1ns/1ps
module led_drive_blanking_offtime_ctrl_tb_top;
    import ledbco_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  sel_req = 4'h0, led_select;
    logic        drv_req = 1'b0, lowr_req = 1'b0, diss_req = 1'b0, pready, pslverr, err;
    logic        photo_comp, peak_limit_trip, cap_mode_select, buck_drive_enable;
    logic        low_r_shunt_enable, dissipative_shunt_enable;
    logic [9:0]  peak_limit_dac;
    wire  [7:0]  vec = {cap_mode_select, buck_drive_enable, low_r_shunt_enable, dissipative_shunt_enable, led_select};
    int          bad_count = 0, n_checks = 0;

    ledbco_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .led_select_req(sel_req), .drive_enable_req(drv_req), .low_r_shunt_req(lowr_req),
        .dissipative_shunt_req(diss_req), .photo_comp(photo_comp), .peak_limit_trip(peak_limit_trip),
        .cap_mode_select(cap_mode_select), .buck_drive_enable(buck_drive_enable),
        .low_r_shunt_enable(low_r_shunt_enable), .dissipative_shunt_enable(dissipative_shunt_enable),
        .led_select(led_select), .peak_limit_dac(peak_limit_dac)
    );
    ledbco_far_model far (
        .pclk(pclk), .presetn(presetn), .buck_drive_enable(buck_drive_enable),
        .low_r_shunt_enable(low_r_shunt_enable), .led_select(led_select),
        .peak_limit_dac(peak_limit_dac), .photo_comp(photo_comp), .peak_limit_trip(peak_limit_trip)
    );

    initial forever #25 pclk = ~pclk;

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Read data and response are taken at the rising edge at which pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rd);
    endtask

    task automatic outs(input int n, input logic [7:0] e);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        chk("outputs", {24'h0, e}, {24'h0, vec});
        @(posedge pclk);
    endtask

    task automatic off_len(input int e);
        int n = 0;
        // The drive must first be seen on, so an idle low level is not taken for off time.
        do @(negedge pclk); while (buck_drive_enable !== 1'b1);
        do @(negedge pclk); while (buck_drive_enable !== 1'b0);
        while (buck_drive_enable === 1'b0 && n < 100) begin
            n++;
            @(negedge pclk);
        end
        chk("off cycles", e, n);
        @(posedge pclk);
    endtask

    initial begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        outs(0, 8'h00);
        rd_chk(LEDBCO_CTRL_OFFSET, LEDBCO_CTRL_RESET);
        rd_chk(LEDBCO_OFFT_OFFSET, {16'h0, LEDBCO_OFFT_RESET});
        rd_chk(LEDBCO_STATUS_OFFSET, 32'h21);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        apb(1'b1, LEDBCO_PEAK_LIMIT_DAC_OFFSET, 32'h40);
        apb(1'b1, LEDBCO_OFFT_OFFSET, 32'h5);
        rd_chk(LEDBCO_OFFT_OFFSET, 32'h5);
        chk("peak_limit_dac", 32'h40, {22'h0, peak_limit_dac});
        $display("test registers done");
        apb(1'b1, LEDBCO_CTRL_OFFSET, 32'h2);
        diss_req <= 1'b1;
        outs(5, 8'h10);
        rd_chk(LEDBCO_STATUS_OFFSET, 32'h22);
        diss_req <= 1'b0;
        lowr_req <= 1'b1;
        outs(5, 8'h60);
        rd_chk(LEDBCO_STATUS_OFFSET, 32'h24);
        outs(80, 8'h20);
        sel_req <= 4'h5;
        drv_req <= 1'b1;
        outs(4, 8'h20);
        lowr_req <= 1'b0;
        do @(negedge pclk); while (low_r_shunt_enable === 1'b1);
        chk("toggle", 32'h05, {24'h0, vec});
        @(negedge pclk);
        chk("toggle", 32'h05, {24'h0, vec});
        @(negedge pclk);
        chk("drive", 32'h1, {31'h0, buck_drive_enable});
        @(posedge pclk);
        $display("test blanking done");
        off_len(7);
        drv_req <= 1'b0;
        outs(6, 8'h00);
        apb(1'b1, LEDBCO_OFFT_OFFSET, 32'hc);
        drv_req <= 1'b1;
        off_len(14);
        $display("test off time done");
        apb(1'b1, LEDBCO_CTRL_OFFSET, 32'h3);
        outs(3, 8'h80);
        drv_req <= 1'b0;
        apb(1'b1, LEDBCO_CTRL_OFFSET, 32'h2);
        outs(3, 8'h00);
        $display("test mode done");
        final_report();
    end
endmodule
